// *** hw/adc_serial_read.sv ***
// serial read port: data-ready timing, result shift-out, aux input capture
//
// Behaviour
// - ready stays high at least 280/N or 560/N
// - idle-low clock needs select toggling; edges swap
// - data changes on falling edge, sampled rising
// - first read of new result raises ready
// - repeated reads return same result
// - aux pins captured at first falling edge
// - aux1 to bit D4, aux0 to D3
// - reset low restores power-on state
// - select tied low gives three-wire mode
`timescale 1ns/100ps
`default_nettype none
module adc_serial_read
    import adc_serial_pkg::*;
#(
    parameter int unsigned WIDTH = RESULT_WIDTH
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // rate configuration
    input wire logic clock_doubler_select,
    input wire logic modulator_rate_hi,
    input wire logic modulator_rate_lo,
    // new conversion result from the datapath
    input wire logic [WIDTH-1:0] result_data,
    input wire logic result_valid,
    // auxiliary digital pins
    input wire logic aux_input_0,
    input wire logic aux_input_1,
    // serial pins
    input wire logic sclk,
    input wire logic cs_n,
    output logic dout,
    output logic dout_oe,
    // data-ready indicator, active low
    output logic ready_n,
    // status
    output logic update_refused
);
    if (WIDTH < AUX1_RESULT_POS + 1 || WIDTH > 32) begin : g_width_check
        $error("adc_serial_read: WIDTH out of range");
    end

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic sclk_lvl;
    logic sclk_rise;
    logic sclk_fall;
    logic cs_lvl;
    logic cs_rise;
    logic cs_fall;
    logic aux0_s1;
    logic aux0_s2;
    logic aux1_s1;
    logic aux1_s2;

    edge_sync u_sclk_sync (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .async_in(sclk),
        .reset_level(1'b1),
        .level(sclk_lvl),
        .rise(sclk_rise),
        .fall(sclk_fall)
    );

    edge_sync u_cs_sync (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .async_in(cs_n),
        .reset_level(1'b1),
        .level(cs_lvl),
        .rise(cs_rise),
        .fall(cs_fall)
    );

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            aux0_s1 <= 1'b0;
            aux0_s2 <= 1'b0;
            aux1_s1 <= 1'b0;
            aux1_s2 <= 1'b0;
        end else begin
            aux0_s1 <= aux_input_0;
            aux0_s2 <= aux0_s1;
            aux1_s1 <= aux_input_1;
            aux1_s2 <= aux1_s1;
        end
    end

    // ------------------------------------------------------------
    // data-ready high time
    // ------------------------------------------------------------
    // N = 2^(2*hi + lo); the minimum is a master-clock count, which this
    // block takes to be core_clk cycles
    function automatic logic [9:0] ready_high_cycles(input logic x2,
            input logic hi, input logic lo);
        logic [9:0] base;
        logic [2:0] shift;
        base = x2 ? 10'(READY_HIGH_BASE_X2) : 10'(READY_HIGH_BASE);
        shift = {hi, 1'b0} + {2'b00, lo};
        return base >> shift;
    endfunction

    // ------------------------------------------------------------
    // frame, edge convention, result holding
    // ------------------------------------------------------------
    frame_state_t state;
    frame_state_t next_state;
    logic idle_low;
    logic next_idle_low;
    logic [WIDTH-1:0] result;
    logic [WIDTH-1:0] next_result;
    logic [WIDTH-1:0] shifter;
    logic [WIDTH-1:0] next_shifter;
    logic first_edge;
    logic next_first_edge;
    logic next_dout;
    logic next_dout_oe;
    logic next_ready_n;
    logic [9:0] high_count;
    logic [9:0] next_high_count;
    logic pending;
    logic next_pending;
    logic next_update_refused;
    logic [WIDTH-1:0] held;
    logic [WIDTH-1:0] next_held;
    logic [$clog2(WIDTH+1)-1:0] bit_count;
    logic [$clog2(WIDTH+1)-1:0] next_bit_count;
    logic word_done;
    logic take_aux;
    logic shift_edge;
    logic sample_edge;
    logic frame_start;
    logic frame_end;

    // idle-low operation swaps which edge launches data
    always_comb begin
        shift_edge = idle_low ? sclk_rise : sclk_fall;
        sample_edge = idle_low ? sclk_fall : sclk_rise;
        // with select tied low a frame opens on the first shift edge
        frame_start = (state == FRAME_IDLE) && !cs_lvl
            && (cs_fall || shift_edge);
        frame_end = cs_rise;
        take_aux = shift_edge
            && (frame_start || (state == FRAME_ACTIVE && first_edge));
    end

    always_comb begin
        next_state = state;
        next_idle_low = idle_low;
        next_result = result;
        next_shifter = shifter;
        next_first_edge = first_edge;
        next_dout = dout;
        next_dout_oe = dout_oe;
        next_ready_n = ready_n;
        next_high_count = high_count;
        next_pending = pending;
        next_held = held;
        next_update_refused = 1'b0;

        if (high_count != 10'h000) begin
            next_high_count = high_count - 10'h001;
        end

        // idle level seen at select fall fixes the convention
        if (state == FRAME_IDLE && cs_fall) begin
            next_idle_low = !sclk_lvl;
        end

        if (result_valid) begin
            // a new result never tears a read in progress; it waits in
            // the holding word until the port is idle and the time is up
            next_held = result_data;
            next_pending = 1'b1;
            next_update_refused = (state != FRAME_IDLE);
        end

        unique case (state)
            FRAME_IDLE: begin
                next_dout_oe = 1'b0;
                // result only changes while the flag falls, so rereads match
                if ((result_valid || pending) && high_count == 10'h000) begin
                    next_result = result_valid ? result_data : held;
                    next_pending = 1'b0;
                    next_ready_n = 1'b0;
                end
                if (frame_start) begin
                    next_state = FRAME_ACTIVE;
                    next_shifter = next_result;
                    next_first_edge = 1'b1;
                    next_dout_oe = 1'b1;
                    next_dout = next_result[WIDTH-1];
                end
            end
            FRAME_ACTIVE: begin
                if (shift_edge && !first_edge) begin
                    next_shifter = {shifter[WIDTH-2:0], 1'b0};
                    next_dout = shifter[WIDTH-2];
                end
                if (frame_end || word_done) begin
                    next_state = FRAME_DONE;
                end
            end
            FRAME_DONE: begin
                next_dout_oe = 1'b0;
                next_state = FRAME_IDLE;
            end
            default: begin
                next_state = FRAME_IDLE;
                next_dout_oe = 1'b0;
            end
        endcase

        // in three-wire mode the opening shift edge is also the first one
        if (take_aux) begin
            next_shifter[AUX1_RESULT_POS] = aux1_s2;
            next_shifter[AUX0_RESULT_POS] = aux0_s2;
            next_first_edge = 1'b0;
            if (!next_ready_n) begin
                next_ready_n = 1'b1;
                next_high_count = ready_high_cycles(
                    clock_doubler_select, modulator_rate_hi,
                    modulator_rate_lo);
            end
        end
    end

    // select held low never raises; release data after last sample edge
    always_comb begin
        next_bit_count = bit_count;
        if (state != FRAME_ACTIVE) begin
            next_bit_count = '0;
        end else if (sample_edge) begin
            next_bit_count = bit_count + 1'b1;
        end
        word_done = (state == FRAME_ACTIVE) && sample_edge
            && (bit_count == ($clog2(WIDTH+1))'(WIDTH - 1));
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            state <= FRAME_IDLE;
            idle_low <= 1'b0;
            result <= RESULT_RESET;
            shifter <= RESULT_RESET;
            first_edge <= 1'b0;
            dout <= 1'b0;
            dout_oe <= 1'b0;
            ready_n <= 1'b1;
            high_count <= 10'h000;
            pending <= 1'b0;
            held <= RESULT_RESET;
            update_refused <= 1'b0;
            bit_count <= '0;
        end else begin
            state <= next_state;
            held <= next_held;
            idle_low <= next_idle_low;
            result <= next_result;
            shifter <= next_shifter;
            first_edge <= next_first_edge;
            dout <= next_dout;
            dout_oe <= next_dout_oe;
            ready_n <= next_ready_n;
            high_count <= next_high_count;
            pending <= next_pending;
            update_refused <= next_update_refused;
            bit_count <= next_bit_count;
        end
    end
endmodule
`default_nettype wire

// *** hw/adc_serial_pkg.sv ***
// shared constants for the converter serial read port
package adc_serial_pkg;
    // ------------------------------------------------------------
    // data-ready high time, in master-clock periods before divide by N
    // ------------------------------------------------------------
    localparam int unsigned READY_HIGH_BASE = 280;
    localparam int unsigned READY_HIGH_BASE_X2 = 560;
    // ------------------------------------------------------------
    // result word layout
    // ------------------------------------------------------------
    localparam int unsigned RESULT_WIDTH = 24;
    localparam int unsigned AUX1_RESULT_POS = 4;
    localparam int unsigned AUX0_RESULT_POS = 3;
    localparam logic [23:0] RESULT_RESET = 24'h000000;
    // ------------------------------------------------------------
    // serial frame states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        FRAME_IDLE = 2'b00,
        FRAME_ACTIVE = 2'b01,
        FRAME_DONE = 2'b10
    } frame_state_t;
endpackage

// *** hw/edge_sync.sv ***
// two-flop synchroniser with edge detection on the synchronised level
`timescale 1ns/100ps
`default_nettype none
module edge_sync (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // asynchronous level in
    input wire logic async_in,
    input wire logic reset_level,
    // synchronised level and edges
    output logic level,
    output logic rise,
    output logic fall
);
    logic stage1;
    logic stage2;
    logic stage3;
    logic next_stage1;
    logic next_stage2;
    logic next_stage3;

    always_comb begin
        next_stage1 = async_in;
        next_stage2 = stage1;
        next_stage3 = stage2;
    end

    // reset loads the pin's idle level so that no false edge follows reset
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            stage1 <= reset_level;
            stage2 <= reset_level;
            stage3 <= reset_level;
        end else begin
            stage1 <= next_stage1;
            stage2 <= next_stage2;
            stage3 <= next_stage3;
        end
    end

    assign level = stage2;
    assign rise = stage2 && !stage3;
    assign fall = !stage2 && stage3;
endmodule
`default_nettype wire

// *** tb/host_reader.sv ***
// host model: serial master that reads result words from the port
`timescale 1ns/100ps
`default_nettype none
module host_reader (
    // clock
    input wire logic core_clk,
    // serial pins
    input wire logic dout,
    input wire logic dout_oe,
    output logic sclk,
    output logic cs_n
);
    initial begin
        sclk = 1'b1;
        cs_n = 1'b1;
    end
    // shift edge leaves idle, sample on the return; half period 4 cycles
    task automatic read_word(input logic idle_low, input logic keep_cs,
        output logic [23:0] w);
        sclk <= ~idle_low;
        repeat (8) @(posedge core_clk);
        cs_n <= 1'b0;
        repeat (8) @(posedge core_clk);
        for (int i = 23; i >= 0; i--) begin
            sclk <= idle_low;
            repeat (4) @(posedge core_clk);
            // an undriven line must never pass for data
            w[i] = dout_oe ? dout : 1'bx;
            sclk <= ~idle_low;
            repeat (4) @(posedge core_clk);
        end
        cs_n <= keep_cs ? 1'b0 : 1'b1;
        repeat (8) @(posedge core_clk);
    endtask
endmodule
`default_nettype wire

// *** tb/adc_serial_read_checker.sv ***
// assertions on the converter serial read port
`timescale 1ns/100ps
`default_nettype none
module adc_serial_read_checker
    import adc_serial_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // watched ports
    input wire logic clock_doubler_select,
    input wire logic modulator_rate_hi,
    input wire logic modulator_rate_lo,
    input wire logic result_valid,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic dout_oe,
    input wire logic ready_n,
    input wire logic update_refused
);
    // saturates so the first result after reset may flag at once
    logic [9:0] hcnt;
    logic [9:0] next_hcnt;
    logic [9:0] limit;
    assign limit = (clock_doubler_select ? 10'(READY_HIGH_BASE_X2)
        : 10'(READY_HIGH_BASE)) >> {modulator_rate_hi, modulator_rate_lo};
    always_comb begin
        next_hcnt = ready_n ? hcnt + 10'(hcnt != 10'h3FF) : 10'h000;
    end
    always_ff @(posedge core_clk) begin
        hcnt <= rst_n ? next_hcnt : 10'h3FF;
    end
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);
    a_reset_quiet: assert property (disable iff (1'b0)
        !rst_n |=> !dout_oe && ready_n && !update_refused)
        else $error("outputs not quiet after reset");
    a_ready_min_high: assert property (
        $fell(ready_n) |-> hcnt >= limit) else $error("ready high too short");
    a_ready_flags: assert property (
        result_valid && cs_n && !dout_oe && hcnt >= limit + 10'h002
        |=> !ready_n) else $error("ready not flagged");
    a_ready_clears: assert property (
        $fell(sclk) && !cs_n && !ready_n |-> ##[1:6] ready_n)
        else $error("ready not cleared by read");
    a_oe_opens: assert property (
        $fell(cs_n) |-> ##[2:6] dout_oe) else $error("no drive after select");
    a_oe_release: assert property (
        $rose(cs_n) |-> ##[1:6] !dout_oe) else $error("drive not released");
    a_idle_quiet: assert property (
        cs_n [*8] |-> !dout_oe) else $error("driving while deselected");
    a_refuse_cause: assert property (
        update_refused |-> result_valid || $past(result_valid))
        else $error("refusal without cause");
    a_refuse_pulse: assert property (
        update_refused |=> !update_refused) else $error("refusal not a pulse");
    cover property ($fell(ready_n));
    cover property (update_refused);
    cover property ($rose(dout_oe) && !sclk);
endmodule
bind adc_serial_read adc_serial_read_checker u_checker (
    .core_clk(core_clk), .rst_n(rst_n),
    .clock_doubler_select(clock_doubler_select),
    .modulator_rate_hi(modulator_rate_hi),
    .modulator_rate_lo(modulator_rate_lo), .result_valid(result_valid),
    .sclk(sclk), .cs_n(cs_n), .dout_oe(dout_oe), .ready_n(ready_n),
    .update_refused(update_refused)
);
`default_nettype wire

// *** tb/tb_adc_serial_read.sv ***
// self-checking bench for the converter serial read port
`timescale 1ns/100ps
`default_nettype none
module tb_adc_serial_read;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic clock_doubler_select = 1'b0;
    logic modulator_rate_hi = 1'b1;
    logic modulator_rate_lo = 1'b1;
    logic [23:0] result_data = 24'h000000;
    logic result_valid = 1'b0;
    logic aux_input_0 = 1'b0;
    logic aux_input_1 = 1'b1;
    logic sclk, cs_n, dout, dout_oe, ready_n, update_refused;
    logic [23:0] word;
    int n_errors = 0;
    int total_checks = 0;
    always #10 core_clk = ~core_clk;
    adc_serial_read u_dut (
        .core_clk(core_clk), .rst_n(rst_n),
        .clock_doubler_select(clock_doubler_select),
        .modulator_rate_hi(modulator_rate_hi),
        .modulator_rate_lo(modulator_rate_lo),
        .result_data(result_data), .result_valid(result_valid),
        .aux_input_0(aux_input_0), .aux_input_1(aux_input_1),
        .sclk(sclk), .cs_n(cs_n), .dout(dout), .dout_oe(dout_oe),
        .ready_n(ready_n), .update_refused(update_refused)
    );
    host_reader u_host (
        .core_clk(core_clk), .dout(dout), .dout_oe(dout_oe),
        .sclk(sclk), .cs_n(cs_n)
    );
    task automatic check(input string what, input logic [31:0] seen, exp);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    task automatic load(input logic [23:0] d);
        tick(1);
        result_data <= d;
        result_valid <= 1'b1;
        tick(1);
        result_valid <= 1'b0;
    endtask
    function automatic logic [23:0] with_aux(input logic [23:0] d);
        with_aux = {d[23:5], aux_input_1, aux_input_0, d[2:0]};
    endfunction
    task automatic t_reset();
        tick(2);
        check("oe in reset", dout_oe, 1'b0);
        check("ready in reset", ready_n, 1'b1);
        rst_n <= 1'b1;
        tick(4);
    endtask
    task automatic t_first_read();
        load(24'hA5C3E7);
        tick(2);
        check("ready flagged", ready_n, 1'b0);
        u_host.read_word(1'b0, 1'b0, word);
        check("word", word, with_aux(24'hA5C3E7));
        check("ready cleared", ready_n, 1'b1);
        check("oe released", dout_oe, 1'b0);
        aux_input_1 <= 1'b0;
        aux_input_0 <= 1'b1;
        u_host.read_word(1'b0, 1'b0, word);
        check("reread", word, with_aux(24'hA5C3E7));
        check("ready kept", ready_n, 1'b1);
    endtask
    // longest high time: doubler on, N of 1, so 560 cycles
    task automatic t_hold_time();
        int n;
        clock_doubler_select <= 1'b1;
        modulator_rate_hi <= 1'b0;
        modulator_rate_lo <= 1'b0;
        tick(200);
        load(24'h3C5A96);
        u_host.read_word(1'b1, 1'b0, word);
        check("idle-low word", word, with_aux(24'h3C5A96));
        load(24'h0F1E2D);
        tick(2);
        check("ready held", ready_n, 1'b1);
        n = 0;
        while (ready_n !== 1'b0 && n < 600) begin
            tick(1);
            n++;
        end
        check("ready falls", ready_n, 1'b0);
        check("high time left", n > 300, 1'b1);
        clock_doubler_select <= 1'b0;
        modulator_rate_hi <= 1'b1;
        modulator_rate_lo <= 1'b1;
    endtask
    task automatic t_three_wire();
        u_host.read_word(1'b0, 1'b1, word);
        check("framed", word, with_aux(24'h0F1E2D));
        u_host.read_word(1'b0, 1'b1, word);
        check("3-wire", word, with_aux(24'h0F1E2D));
    endtask
    task automatic t_refuse();
        logic seen;
        seen = 1'b0;
        fork
            u_host.read_word(1'b0, 1'b0, word);
            begin
                tick(60);
                load(24'h5A5A5A);
                repeat (4) begin
                    tick(1);
                    seen |= update_refused;
                end
            end
        join
        check("refused", seen, 1'b1);
        check("old word", word, with_aux(24'h0F1E2D));
        tick(8);
        check("deferred ready", ready_n, 1'b0);
        u_host.read_word(1'b0, 1'b0, word);
        check("deferred", word, with_aux(24'h5A5A5A));
    endtask
    initial begin
        t_reset();
        t_first_read();
        t_hold_time();
        t_three_wire();
        t_refuse();
        give_verdict();
    end
    initial begin
        tick(20000);
        n_errors++;
        give_verdict();
    end
endmodule
`default_nettype wire
